// ---- fqp_pkg.sv ----
package fqp_pkg;
   // Bus geometry: byte address, one 32-bit word per query location
   localparam int ADDR_W = 12;
   localparam int IDX_W  = 10;
   localparam int IDX_LSB = 2;
   localparam int DATA_W = 32;
   localparam int BE_W   = 4;

   // Query location indices; byte address is four times the index
   localparam logic [IDX_W-1:0] IDX_T1_GEOM = 10'h136;
   localparam logic [IDX_W-1:0] IDX_T1_END  = 10'h13a;
   localparam logic [IDX_W-1:0] IDX_T1_CELL = 10'h13c;
   localparam logic [IDX_W-1:0] IDX_T1_CAP  = 10'h13d;
   localparam logic [IDX_W-1:0] IDX_T1_PROG = 10'h13e;
   localparam logic [IDX_W-1:0] IDX_T2_GEOM = 10'h144;
   localparam logic [IDX_W-1:0] IDX_T2_END  = 10'h148;
   localparam logic [IDX_W-1:0] IDX_T2_CELL = 10'h14a;
   localparam logic [IDX_W-1:0] IDX_T2_CAP  = 10'h14b;
   localparam logic [IDX_W-1:0] IDX_LAST    = 10'h14b;

   // Control and decoded status words
   localparam logic [IDX_W-1:0] IDX_CTRL    = 10'h180;
   localparam logic [IDX_W-1:0] IDX_T1_CNT  = 10'h181;
   localparam logic [IDX_W-1:0] IDX_T1_SIZE = 10'h182;
   localparam logic [IDX_W-1:0] IDX_T2_CNT  = 10'h183;
   localparam logic [IDX_W-1:0] IDX_T2_SIZE = 10'h184;

   localparam int ROM_BYTES = 22;
   localparam int ROM_AW    = 5;

   // Field layout
   localparam int CNT_W    = 16;
   localparam int SIZE_LSB = 16;
   localparam int UNIT_SH  = 8;
   localparam int BYTES_W  = CNT_W + UNIT_SH;
   localparam int CTRL_BOTTOM_BIT = 0;
   localparam logic CTRL_BOTTOM_RST = 1'b1;

   // Reserved bits read as zero; hidden type 2 bytes read erased
   localparam logic [7:0]  CELL_MASK = 8'h1f;
   localparam logic [7:0]  CAP_MASK  = 8'h07;
   localparam logic [47:0] PROG_MASK = 48'h80ff_00ff_80ff;
   localparam logic [7:0]  ERASED    = 8'hff;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_FETCH = 4'b0010,
      ST_LOAD  = 4'b0100,
      ST_ACK   = 4'b1000
   } fqp_state_t;
endpackage

// ---- fqp_rom.sv ----
`timescale 1ns/100ps
module fqp_rom #(
   parameter int                    N_BYTES = 22,
   parameter int                    AW      = 5,
   parameter logic [8*N_BYTES-1:0] IMG     = '0
) (
   input  wire logic          ref_clk,
   input  wire logic          rst_n,
   input  wire logic [AW-1:0] idx,
   output logic      [7:0]    data
);
   typedef struct packed {
      logic [7:0] q;
   } fqp_rom_st_t;

   fqp_rom_st_t r;
   fqp_rom_st_t n;

   always_comb begin
      n = r;
      if (int'(idx) < N_BYTES) begin
         n.q = IMG[8*idx +: 8];
      end else begin
         n.q = 8'h00;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign data = r.q;
endmodule

// ---- fqp_geom_decode.sv ----
`timescale 1ns/100ps
module fqp_geom_decode
   import fqp_pkg::*;
#(
   parameter int NT = 2
) (
   input  wire logic                      ref_clk,
   input  wire logic                      rst_n,
   input  wire logic [NT-1:0][31:0]       geom,
   output logic      [NT-1:0][CNT_W:0]    blk_count,
   output logic      [NT-1:0][BYTES_W-1:0] blk_bytes
);
   typedef struct packed {
      logic [NT-1:0][CNT_W:0]     cnt;
      logic [NT-1:0][BYTES_W-1:0] bytes;
   } fqp_dec_st_t;

   fqp_dec_st_t r;
   fqp_dec_st_t n;
   logic [NT-1:0][CNT_W:0]     cnt_n;
   logic [NT-1:0][BYTES_W-1:0] bytes_n;

   genvar g;
   generate
      for (g = 0; g < NT; g++) begin : g_type
         // Count is y plus one; wider by a bit so ffffh does not wrap
         assign cnt_n[g] = {1'b0, geom[g][CNT_W-1:0]} + 17'h00001;
         // Size field is in 256-byte units
         assign bytes_n[g] = {geom[g][SIZE_LSB +: CNT_W], 8'h00};
      end
   endgenerate

   always_comb begin
      n = r;
      n.cnt = cnt_n;
      n.bytes = bytes_n;
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= '0;
      end else begin
         r <= n;
      end
   end

   assign blk_count = r.cnt;
   assign blk_bytes = r.bytes;
endmodule

// ---- fqp_query_rom.sv ----
// The Avalon-MM slave port was decided locally.
`timescale 1ns/100ps
// Overview of operation
// - Type 1 block count minus one at 136h
// - Type 1 block size in 256-byte units
// - Type 1 erase endurance, thousands, at 13Ah
// - Type 1 bits per cell, reserved bits 13Ch
// - Type 1 page/sync capability flags at 13Dh
// - Type 1 program region size, legacy bit 15
// - Control mode sizes, legacy bit 47
// - Type 2 geometry at 144h, bottom only
// - Type 2 erase endurance at 148h
// - Type 2 cell info at 14Ah
// - Type 2 capability flags at 14Bh
module fqp_query_rom #(
   parameter logic [31:0] T1_GEOM = 32'h0080_0003,
   parameter logic [15:0] T1_END  = 16'h0064,
   parameter logic [7:0]  T1_CELL = 8'h02,
   parameter logic [7:0]  T1_CAP  = 8'h03,
   parameter logic [47:0] T1_PROG = 48'h8000_0000_8000,
   parameter logic [31:0] T2_GEOM = 32'h0200_01fe,
   parameter logic [15:0] T2_END  = 16'h0064,
   parameter logic [7:0]  T2_CELL = 8'h02,
   parameter logic [7:0]  T2_CAP  = 8'h03
) (
   input  wire logic                          ref_clk,
   input  wire logic                          rst_n,
   input  wire logic [fqp_pkg::ADDR_W-1:0]    avs_address,
   input  wire logic                          avs_read,
   input  wire logic                          avs_write,
   input  wire logic [fqp_pkg::DATA_W-1:0]    avs_writedata,
   input  wire logic [fqp_pkg::BE_W-1:0]      avs_byteenable,
   output logic      [fqp_pkg::DATA_W-1:0]    avs_readdata,
   output logic                               avs_waitrequest
);
   import fqp_pkg::*;

   // Reserved bits are masked so a careless parameter cannot leak them
   localparam logic [8*ROM_BYTES-1:0] IMG = {
      T2_CAP & CAP_MASK,
      T2_CELL & CELL_MASK,
      T2_END,
      T2_GEOM,
      T1_PROG & PROG_MASK,
      T1_CAP & CAP_MASK,
      T1_CELL & CELL_MASK,
      T1_END,
      T1_GEOM
   };

   typedef struct packed {
      fqp_state_t        st;
      logic [IDX_W-1:0]  idx;
      logic              bottom;
      logic [DATA_W-1:0] rdata;
      logic              waitreq;
   } fqp_main_st_t;

   localparam fqp_main_st_t RST_VAL = '{
      st:      ST_IDLE,
      idx:     '0,
      bottom:  CTRL_BOTTOM_RST,
      rdata:   '0,
      waitreq: 1'b1
   };

   fqp_main_st_t r;
   fqp_main_st_t n;

   logic [IDX_W-1:0]          rom_off;
   logic [ROM_AW-1:0]         rom_idx;
   logic [7:0]                rom_q;
   logic                      in_rom;
   logic                      is_t2;
   logic [7:0]                rom_byte;
   logic [DATA_W-1:0]         sel_data;
   logic [1:0][31:0]          geom;
   logic [1:0][CNT_W:0]       blk_count;
   logic [1:0][BYTES_W-1:0]   blk_bytes;
   logic                      ctrl_wr;

   assign geom[0] = T1_GEOM;
   assign geom[1] = T2_GEOM;

   // Location decode on the latched index, stable while the ROM fetches
   assign rom_off = r.idx - IDX_T1_GEOM;
   assign rom_idx = rom_off[ROM_AW-1:0];
   assign in_rom  = (r.idx >= IDX_T1_GEOM) && (r.idx <= IDX_LAST);
   assign is_t2   = (r.idx >= IDX_T2_GEOM);

   fqp_rom #(
      .N_BYTES (ROM_BYTES),
      .AW      (ROM_AW),
      .IMG     (IMG)
   ) u_rom (
      .ref_clk (ref_clk),
      .rst_n   (rst_n),
      .idx     (rom_idx),
      .data    (rom_q)
   );

   fqp_geom_decode #(
      .NT (2)
   ) u_dec (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .geom      (geom),
      .blk_count (blk_count),
      .blk_bytes (blk_bytes)
   );

   // Non-bottom parts carry no second block type; its query bytes read erased, decoded words at 183h/184h are not gated
   always_comb begin
      if (is_t2 && !r.bottom) begin
         rom_byte = ERASED;
      end else begin
         rom_byte = rom_q;
      end
   end

   always_comb begin
      sel_data = '0;
      if (in_rom) begin
         sel_data = {24'h000000, rom_byte};
      end else begin
         unique case (r.idx)
            IDX_CTRL: begin
               sel_data[CTRL_BOTTOM_BIT] = r.bottom;
            end
            IDX_T1_CNT: begin
               sel_data[CNT_W:0] = blk_count[0];
            end
            IDX_T1_SIZE: begin
               sel_data[BYTES_W-1:0] = blk_bytes[0];
            end
            IDX_T2_CNT: begin
               sel_data[CNT_W:0] = blk_count[1];
            end
            IDX_T2_SIZE: begin
               sel_data[BYTES_W-1:0] = blk_bytes[1];
            end
            default: begin
               sel_data = '0;
            end
         endcase
      end
   end

   // Only the control word takes writes; query locations ignore them
   assign ctrl_wr = avs_write && (r.idx == IDX_CTRL) && avs_byteenable[0];

   always_comb begin
      n = r;
      unique case (r.st)
         ST_IDLE: begin
            if (avs_read) begin
               n.idx = avs_address[ADDR_W-1:IDX_LSB];
               n.st = ST_FETCH;
            end else if (avs_write) begin
               n.idx = avs_address[ADDR_W-1:IDX_LSB];
               n.waitreq = 1'b0;
               n.st = ST_ACK;
            end
         end
         ST_FETCH: begin
            n.st = ST_LOAD;
         end
         ST_LOAD: begin
            n.rdata = sel_data;
            n.waitreq = 1'b0;
            n.st = ST_ACK;
         end
         ST_ACK: begin
            if (ctrl_wr) begin
               n.bottom = avs_writedata[CTRL_BOTTOM_BIT];
            end
            n.waitreq = 1'b1;
            n.st = ST_IDLE;
         end
         default: begin
            n = RST_VAL;
         end
      endcase
   end

   always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
         r <= RST_VAL;
      end else begin
         r <= n;
      end
   end

   assign avs_readdata    = r.rdata;
   assign avs_waitrequest = r.waitreq;

   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_rd_req;
      (r.st == ST_IDLE) && avs_read;
   endsequence

   sequence s_wr_req;
      (r.st == ST_IDLE) && avs_write && !avs_read;
   endsequence

   sequence s_rd_done;
      avs_read && !avs_waitrequest;
   endsequence

   sequence s_wait_fetch;
      avs_waitrequest [*2];
   endsequence

   property p_rd_at(logic [IDX_W-1:0] loc, logic [7:0] val);
      s_rd_done ##0 (r.idx == loc) |-> avs_readdata == {24'h000000, val};
   endproperty

   property p_rd_t2(logic [IDX_W-1:0] loc, logic [7:0] val);
      s_rd_done ##0 (r.idx == loc) |->
         avs_readdata[7:0] == (r.bottom ? val : ERASED);
   endproperty

   a_read_latency: assert property (
      s_rd_req |=> s_wait_fetch ##1 !avs_waitrequest
   ) else $error("read answer not on the third edge");

   a_ack_one_cycle: assert property (
      !avs_waitrequest |=> avs_waitrequest
   ) else $error("waitrequest low for more than one cycle");

   a_write_ack: assert property (
      s_wr_req |=> !avs_waitrequest ##1 (r.st == ST_IDLE)
   ) else $error("write not answered on the next edge");

   a_rom_upper_zero: assert property (
      s_rd_done ##0 in_rom |-> avs_readdata[31:8] == 24'h000000
   ) else $error("query byte not on the low lanes");

   a_ctrl_update: assert property (
      avs_write && !avs_waitrequest && (r.idx == IDX_CTRL) && avs_byteenable[0]
      |=> r.bottom == $past(avs_writedata[CTRL_BOTTOM_BIT])
   ) else $error("control write lost");

   a_rom_no_write: assert property (
      avs_write && !avs_waitrequest && in_rom |=> $stable(r.bottom)
   ) else $error("write to query location altered state");

   a_t1_count_lo: assert property (
      p_rd_at(IDX_T1_GEOM, T1_GEOM[7:0])
   ) else $error("type 1 count low byte wrong");

   a_t1_count_hi: assert property (
      p_rd_at(IDX_T1_GEOM + 10'h001, T1_GEOM[15:8])
   ) else $error("type 1 count high byte wrong");

   a_t1_count_dec: assert property (
      s_rd_done ##0 (r.idx == IDX_T1_CNT) |->
         avs_readdata == 32'(T1_GEOM[CNT_W-1:0]) + 32'h00000001
   ) else $error("type 1 decoded count is not y plus one");

   a_t1_size_bytes: assert property (
      s_rd_done ##0 (r.idx == IDX_T1_SIZE) |->
         avs_readdata == {8'h00, T1_GEOM[31:16], 8'h00}
   ) else $error("type 1 block size not z times 256");

   a_t1_size_raw: assert property (
      p_rd_at(IDX_T1_GEOM + 10'h003, T1_GEOM[31:24])
   ) else $error("type 1 size high byte wrong");

   a_t1_endurance: assert property (
      p_rd_at(IDX_T1_END, T1_END[7:0])
   ) else $error("type 1 endurance low byte wrong");

   a_t1_end_hi: assert property (
      p_rd_at(IDX_T1_END + 10'h001, T1_END[15:8])
   ) else $error("type 1 endurance high byte wrong");

   a_t1_cell_info: assert property (
      s_rd_done ##0 (r.idx == IDX_T1_CELL) |->
         avs_readdata[7:5] == 3'h0 && avs_readdata[4:0] == T1_CELL[4:0]
   ) else $error("type 1 cell byte wrong");

   a_t1_caps: assert property (
      s_rd_done ##0 (r.idx == IDX_T1_CAP) |->
         avs_readdata[7:3] == 5'h00 && avs_readdata[2:0] == T1_CAP[2:0]
   ) else $error("type 1 capability byte wrong");

   a_t1_prog_size: assert property (
      s_rd_done ##0 (r.idx == IDX_T1_PROG + 10'h001) |->
         avs_readdata[6:0] == 7'h00 && avs_readdata[7] == T1_PROG[15]
   ) else $error("programming region reserved or legacy bit wrong");

   a_t1_prog_x: assert property (
      p_rd_at(IDX_T1_PROG, T1_PROG[7:0])
   ) else $error("programming region size field wrong");

   a_t1_ctrl_mode: assert property (
      s_rd_done ##0 (r.idx == IDX_T1_PROG + 10'h005) |->
         avs_readdata[6:0] == 7'h00 && avs_readdata[7] == T1_PROG[47]
   ) else $error("control mode legacy byte wrong");

   a_t1_ctrl_rsvd: assert property (
      p_rd_at(IDX_T1_PROG + 10'h003, 8'h00)
   ) else $error("control mode reserved byte not zero");

   a_t2_geom: assert property (
      p_rd_t2(IDX_T2_GEOM, T2_GEOM[7:0])
   ) else $error("type 2 geometry byte wrong");

   a_t2_endurance: assert property (
      p_rd_t2(IDX_T2_END, T2_END[7:0])
   ) else $error("type 2 endurance byte wrong");

   a_t2_cell_info: assert property (
      p_rd_t2(IDX_T2_CELL, T2_CELL & CELL_MASK)
   ) else $error("type 2 cell byte wrong");

   a_t2_caps: assert property (
      p_rd_t2(IDX_T2_CAP, T2_CAP & CAP_MASK)
   ) else $error("type 2 capability byte wrong");

   // Top-parameter setting must hide every type 2 byte, not only the first of each field
   a_t2_erased_hidden: assert property (
      s_rd_done ##0 (in_rom && is_t2 && !r.bottom) |->
         avs_readdata == {24'h000000, ERASED}
   ) else $error("type 2 byte visible on top-parameter setting");

   a_t2_count_dec: assert property (
      s_rd_done ##0 (r.idx == IDX_T2_CNT) |->
         avs_readdata == 32'(T2_GEOM[CNT_W-1:0]) + 32'h00000001
   ) else $error("type 2 decoded count is not y plus one");

   a_t2_size_bytes: assert property (
      s_rd_done ##0 (r.idx == IDX_T2_SIZE) |->
         avs_readdata == {8'h00, T2_GEOM[31:16], 8'h00}
   ) else $error("type 2 block size not z times 256");

   a_t1_valid_size: assert property (
      p_rd_at(IDX_T1_PROG + 10'h002, T1_PROG[23:16])
   ) else $error("control mode valid size wrong");

   a_t1_invalid_size: assert property (
      p_rd_at(IDX_T1_PROG + 10'h004, T1_PROG[39:32])
   ) else $error("control mode invalid size wrong");

   // Read data only moves when a read loads it, so a slow master still sees it
   a_rdata_hold: assert property (
      (r.st != ST_LOAD) |=> $stable(avs_readdata)
   ) else $error("read data changed outside a read");
endmodule

// ---- fqp_host.sv ----
`timescale 1ns/100ps
module fqp_host (
   input  wire logic                         ref_clk,
   input  wire logic [fqp_pkg::DATA_W-1:0]   avs_readdata,
   input  wire logic                         avs_waitrequest,
   output logic      [fqp_pkg::ADDR_W-1:0]   avs_address,
   output logic                              avs_read,
   output logic                              avs_write,
   output logic      [fqp_pkg::DATA_W-1:0]   avs_writedata,
   output logic      [fqp_pkg::BE_W-1:0]     avs_byteenable
);
   import fqp_pkg::*;

   initial begin
      avs_address    = '0;
      avs_read       = 1'b0;
      avs_write      = 1'b0;
      avs_writedata  = '0;
      avs_byteenable = '0;
   end

   // One transfer; lat counts the edges seen with the slave still stalling
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] wd, input logic [BE_W-1:0] be,
                       output logic [DATA_W-1:0] rd, output int lat);
      lat = 0;
      @(posedge ref_clk);
      avs_address    <= a;
      avs_writedata  <= wd;
      avs_byteenable <= be;
      avs_read       <= !wr;
      avs_write      <= wr;
      forever begin
         @(posedge ref_clk);
         if (avs_waitrequest === 1'b0) break;
         lat++;
      end
      rd = avs_readdata;
      avs_read       <= 1'b0;
      avs_write      <= 1'b0;
      // Idle bus shows inverted leftovers so stale values never look valid
      avs_address    <= ~a;
      avs_writedata  <= ~wd;
      avs_byteenable <= ~be;
   endtask
endmodule

// ---- fqp_query_rom_tb.sv ----
`timescale 1ns/100ps
`define CHK(act, expv) begin \
   total_checks++; \
   if ((act) !== (expv)) begin \
      errors++; \
      $display("ERROR t=%0t mismatch got %h expected %h", $time, (act), (expv)); \
   end \
end

module fqp_query_rom_tb;
   import fqp_pkg::*;

   logic              ref_clk;
   logic              rst_n;
   logic [ADDR_W-1:0] avs_address;
   logic              avs_read;
   logic              avs_write;
   logic [DATA_W-1:0] avs_writedata;
   logic [BE_W-1:0]   avs_byteenable;
   logic [DATA_W-1:0] avs_readdata;
   logic              avs_waitrequest;
   int                errors;
   int                total_checks;

   // Expected bytes 136h..14Bh, bottom-parameter configuration
   logic [7:0] exp_bytes [22] = '{8'h03, 8'h00, 8'h80, 8'h00, 8'h64, 8'h00, 8'h02, 8'h03,
                                  8'h00, 8'h80, 8'h00, 8'h00, 8'h00, 8'h80,
                                  8'hfe, 8'h01, 8'h00, 8'h02, 8'h64, 8'h00, 8'h02, 8'h03};

   fqp_query_rom DUT (
      .ref_clk         (ref_clk),
      .rst_n           (rst_n),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest)
   );

   fqp_host u_host (
      .ref_clk         (ref_clk),
      .avs_readdata    (avs_readdata),
      .avs_waitrequest (avs_waitrequest),
      .avs_address     (avs_address),
      .avs_read        (avs_read),
      .avs_write       (avs_write),
      .avs_writedata   (avs_writedata),
      .avs_byteenable  (avs_byteenable)
   );

   initial begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic end_of_test();
      $display("Checks made: %0d, mismatches: %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task automatic do_reset();
      @(posedge ref_clk);
      rst_n <= 1'b0;
      repeat (16) @(posedge ref_clk);
      `CHK(avs_waitrequest, 1'b1)
      `CHK(avs_readdata, 32'h0)
      rst_n <= 1'b1;
   endtask

   task automatic rd_chk(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] expv);
      logic [DATA_W-1:0] d;
      int                lat;
      u_host.xfer(1'b0, {idx, 2'b00}, 32'h0, 4'hf, d, lat);
      `CHK(d, expv)
      `CHK(lat, 3)
   endtask

   task automatic wr_do(input logic [IDX_W-1:0] idx, input logic [DATA_W-1:0] wd,
                        input logic [BE_W-1:0] be);
      logic [DATA_W-1:0] d;
      int                lat;
      u_host.xfer(1'b1, {idx, 2'b00}, wd, be, d, lat);
      `CHK(lat, 1)
   endtask

   // Every query byte on the low lane, upper lanes zero
   task automatic t_map();
      for (int i = 0; i < 22; i++) begin
         rd_chk(IDX_W'(IDX_T1_GEOM + i), {24'h0, exp_bytes[i]});
      end
   endtask

   // Count is y+1, size is z times 256, both built from the little-endian bytes
   task automatic t_decode();
      rd_chk(IDX_T1_CNT, 32'({exp_bytes[1], exp_bytes[0]}) + 32'h1);
      rd_chk(IDX_T1_SIZE, 32'({exp_bytes[3], exp_bytes[2]}) * 32'd256);
      rd_chk(IDX_T2_CNT, 32'({exp_bytes[15], exp_bytes[14]}) + 32'h1);
      rd_chk(IDX_T2_SIZE, 32'({exp_bytes[17], exp_bytes[16]}) * 32'd256);
   endtask

   task automatic t_readonly();
      wr_do(IDX_T1_GEOM, 32'hffff_ffff, 4'hf);
      wr_do(IDX_T1_CAP, 32'h0000_00f8, 4'hf);
      wr_do(IDX_T1_PROG, 32'h0000_007f, 4'hf);
      wr_do(IDX_T2_END, 32'hffff_ffff, 4'hf);
      wr_do(IDX_CTRL, 32'h0, 4'h0);
      rd_chk(IDX_T1_GEOM, 32'h03);
      rd_chk(IDX_T1_CAP, 32'h03);
      rd_chk(IDX_T1_PROG, 32'h00);
      rd_chk(IDX_T2_END, 32'h64);
      rd_chk(IDX_CTRL, 32'h1);
   endtask

   // Top-parameter setting hides the type 2 query bytes, reset restores bottom setting
   task automatic t_topcfg();
      wr_do(IDX_CTRL, 32'h0, 4'h1);
      rd_chk(IDX_CTRL, 32'h0);
      for (int i = 14; i < 22; i++) begin
         rd_chk(IDX_W'(IDX_T1_GEOM + i), 32'hff);
      end
      rd_chk(IDX_T1_GEOM, 32'h03);
      wr_do(IDX_CTRL, 32'h1, 4'h1);
      rd_chk(IDX_T2_GEOM, 32'hfe);
      wr_do(IDX_CTRL, 32'h0, 4'h1);
      do_reset();
      rd_chk(IDX_CTRL, 32'h1);
      rd_chk(IDX_T2_CAP, 32'h03);
   endtask

   task automatic t_unmapped();
      rd_chk(10'h14c, 32'h0);
      rd_chk(10'h135, 32'h0);
      rd_chk(10'h000, 32'h0);
      rd_chk(10'h3ff, 32'h0);
   endtask

   initial begin
      errors       = 0;
      total_checks = 0;
      rst_n        = 1'b0;
      do_reset();
      t_map();
      t_decode();
      t_readonly();
      t_topcfg();
      t_unmapped();
      end_of_test();
   end

   // Whole run needs well under a thousand cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      $display("ERROR t=%0t watchdog expired", $time);
      end_of_test();
   end
endmodule
